// ### rtl/fsap_status_regs.sv
// status registers, spi command front end and write protection
`include "fsap_cfg.svh"
module fsap_status_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_wp_n,
  input wire logic i_engine_done,
  output logic o_so,
  output logic o_so_oe,
  output logic o_op_start,
  output fsap_pkg::fsap_op_e o_op_kind,
  output logic [23:0] o_op_addr,
  output logic o_suspend_req,
  output logic o_resume_req,
  output logic o_soft_reset,
  output logic o_quad_io_enable,
  output logic [1:0] o_drive_strength,
  output logic o_hold_reset_sel,
  output logic o_dummy_cycle_select
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: sclk, cs_n, si, wp_n
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic sclk_d_r;
  logic cs_d_r;
  logic sclk_s, cs_s, si_s, wp_s, rise, fall, frame_end;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
      sclk_d_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      sync1_r <= {i_sclk, i_cs_n, i_si, i_wp_n};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[3];
      cs_d_r <= sync2_r[2];
    end
  end
  assign {sclk_s, cs_s, si_s, wp_s} = sync2_r;
  assign rise = !cs_s && sclk_s && !sclk_d_r;
  assign fall = !cs_s && !sclk_s && sclk_d_r;
  assign frame_end = cs_s && !cs_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // status fields
  logic [1:0] mode_r;
  logic [4:0] bp_r;
  logic wel_r, cmp_r, qe_r, hold_sel_r, dc_r;
  logic [2:0] lock_r;
  logic [1:0] drv_r;
  logic erase_susp_r, prog_susp_r, op_busy_r, rst_en_r;
  logic [7:0] srw_cnt_r;
  logic busy;
  logic [7:0] sr1_val, sr2_val, sr3_val;

  assign busy = op_busy_r || (srw_cnt_r != 8'h00);
  assign sr1_val = {mode_r[0], bp_r, wel_r, busy};
  assign sr2_val = {erase_susp_r, cmp_r, lock_r, prog_susp_r, qe_r, mode_r[1]};
  assign sr3_val = {hold_sel_r, drv_r, `FSAP_RSVD_ZERO, dc_r};

  ////////////////////////////////////////////////////////////////////////////
  // spi framing
  fsap_pkg::fsap_state_e st_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shin_r, cmd_r;
  logic [23:0] addr_r;
  logic [1:0] abyte_r;
  logic [7:0] data_r;
  logic [7:0] rx_byte;
  logic byte_done;

  assign rx_byte = {shin_r[6:0], si_s};
  assign byte_done = rise && (bit_cnt_r == `FSAP_BYTE_LAST);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= fsap_pkg::ST_CMD;
      bit_cnt_r <= 3'h0;
      shin_r <= 8'h00;
      cmd_r <= 8'h00;
      addr_r <= 24'h000000;
      abyte_r <= 2'h0;
      data_r <= 8'h00;
    end else if (cs_s) begin
      st_r <= fsap_pkg::ST_CMD;
      bit_cnt_r <= 3'h0;
      abyte_r <= 2'h0;
    end else if (rise) begin
      shin_r <= rx_byte;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done) begin
        case (st_r)
          fsap_pkg::ST_CMD: begin
            cmd_r <= rx_byte;
            if (rx_byte == `FSAP_CMD_WRSR1 || rx_byte == `FSAP_CMD_WRSR2 ||
                rx_byte == `FSAP_CMD_WRSR3) begin
              st_r <= fsap_pkg::ST_WDATA;
            end else if (rx_byte == `FSAP_CMD_PP || rx_byte == `FSAP_CMD_SE ||
                         rx_byte == `FSAP_CMD_BE32 || rx_byte == `FSAP_CMD_BE64) begin
              st_r <= fsap_pkg::ST_ADDR;
            end else if (rx_byte == `FSAP_CMD_RDSR1 || rx_byte == `FSAP_CMD_RDSR2 ||
                         rx_byte == `FSAP_CMD_RDSR3) begin
              st_r <= fsap_pkg::ST_RDATA;
            end else begin
              st_r <= fsap_pkg::ST_DONE;
            end
          end
          fsap_pkg::ST_ADDR: begin
            addr_r <= {addr_r[15:0], rx_byte};
            abyte_r <= abyte_r + 2'h1;
            if (abyte_r == `FSAP_ADDR_LAST) begin
              st_r <= fsap_pkg::ST_DONE;
            end
          end
          fsap_pkg::ST_WDATA: begin
            data_r <= rx_byte;
            st_r <= fsap_pkg::ST_DONE;
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status read-out, shifted on the sclk falling edge
  logic [7:0] sh_r;
  logic [2:0] ocnt_r;
  logic so_r;
  logic [7:0] live_val;
  logic rd_load;

  always_comb begin
    if (cmd_r == `FSAP_CMD_RDSR2) begin
      live_val = sr2_val;
    end else if (cmd_r == `FSAP_CMD_RDSR3) begin
      live_val = sr3_val;
    end else begin
      live_val = sr1_val;
    end
  end
  assign rd_load = byte_done && (st_r == fsap_pkg::ST_CMD);

  // each repeated byte re-samples the register so busy can be polled
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_r <= 8'h00;
      ocnt_r <= 3'h0;
      so_r <= 1'b0;
    end else if (rd_load) begin
      ocnt_r <= 3'h0;
      sh_r <= (rx_byte == `FSAP_CMD_RDSR2) ? sr2_val :
              (rx_byte == `FSAP_CMD_RDSR3) ? sr3_val : sr1_val;
    end else if (fall && st_r == fsap_pkg::ST_RDATA) begin
      so_r <= sh_r[7];
      ocnt_r <= ocnt_r + 3'h1;
      sh_r <= (ocnt_r == `FSAP_BYTE_LAST) ? live_val : {sh_r[6:0], 1'b0};
    end
  end
  assign o_so = so_r;
  assign o_so_oe = !cs_s && (st_r == fsap_pkg::ST_RDATA);

  ////////////////////////////////////////////////////////////////////////////
  // command commit at chip-select release
  logic do_end, is_wrsr, is_op, is_chip, sr_unlocked, wr_ok;
  logic addr_prot, ce_ok, susp_any;
  logic srw_go, op_go, wren_go, wrdi_go, susp_go, resume_go, rst_go;

  fsap_prot_decode u_decode (
    .i_bp(bp_r),
    .i_cmp(cmp_r),
    .i_addr(addr_r),
    .o_protected(addr_prot),
    .o_chip_erase_ok(ce_ok)
  );

  assign do_end = frame_end && (st_r == fsap_pkg::ST_DONE);
  assign is_wrsr = (cmd_r == `FSAP_CMD_WRSR1) || (cmd_r == `FSAP_CMD_WRSR2) ||
                   (cmd_r == `FSAP_CMD_WRSR3);
  assign is_chip = (cmd_r == `FSAP_CMD_CE1) || (cmd_r == `FSAP_CMD_CE2);
  assign is_op = is_chip || (cmd_r == `FSAP_CMD_PP) || (cmd_r == `FSAP_CMD_SE) ||
                 (cmd_r == `FSAP_CMD_BE32) || (cmd_r == `FSAP_CMD_BE64);
  assign susp_any = erase_susp_r || prog_susp_r;
  // lock-down and one-time modes refuse every status write
  assign sr_unlocked = (mode_r == `FSAP_MODE_SW) || ((mode_r == `FSAP_MODE_HW) && wp_s);
  assign wr_ok = wel_r && !busy;
  assign srw_go = do_end && is_wrsr && wr_ok && sr_unlocked;
  assign op_go = do_end && is_op && wr_ok && !susp_any &&
                 (is_chip ? ce_ok : !addr_prot);
  assign wren_go = do_end && (cmd_r == `FSAP_CMD_WREN);
  assign wrdi_go = do_end && (cmd_r == `FSAP_CMD_WRDI);
  assign susp_go = do_end && (cmd_r == `FSAP_CMD_SUSP) && op_busy_r;
  assign resume_go = do_end && (cmd_r == `FSAP_CMD_RESUME) && susp_any;
  assign rst_go = do_end && (cmd_r == `FSAP_CMD_RST) && rst_en_r;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wel_r <= 1'b0;
      rst_en_r <= 1'b0;
    end else if (do_end) begin
      rst_en_r <= (cmd_r == `FSAP_CMD_RSTEN);
      if (rst_go || wrdi_go || ((is_wrsr || is_op) && !busy)) begin
        wel_r <= 1'b0;
      end else if (wren_go) begin
        wel_r <= 1'b1;
      end
    end
  end

  // non-volatile fields take their delivery values at reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= `FSAP_RST_MODE;
      bp_r <= `FSAP_RST_BP;
      cmp_r <= 1'b0;
      lock_r <= `FSAP_RST_LOCK;
      qe_r <= 1'b0;
      hold_sel_r <= 1'b0;
      drv_r <= `FSAP_RST_DRV;
      dc_r <= 1'b0;
    end else if (srw_go) begin
      if (cmd_r == `FSAP_CMD_WRSR1) begin
        mode_r[0] <= data_r[7];
        bp_r <= data_r[6:2];
      end else if (cmd_r == `FSAP_CMD_WRSR2) begin
        cmp_r <= data_r[6];
        lock_r <= lock_r | data_r[5:3];
        qe_r <= data_r[1];
        mode_r[1] <= data_r[0];
      end else begin
        hold_sel_r <= data_r[7];
        drv_r <= data_r[6:5];
        dc_r <= data_r[0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_busy_r <= 1'b0;
      srw_cnt_r <= 8'h00;
      o_op_start <= 1'b0;
      o_op_kind <= fsap_pkg::OP_PROG;
      o_op_addr <= 24'h000000;
      o_suspend_req <= 1'b0;
      o_resume_req <= 1'b0;
      o_soft_reset <= 1'b0;
    end else begin
      o_op_start <= op_go;
      o_suspend_req <= susp_go;
      o_resume_req <= resume_go;
      o_soft_reset <= rst_go;
      if (srw_go) begin
        srw_cnt_r <= 8'(`FSAP_SRW_CYC);
      end else if (srw_cnt_r != 8'h00) begin
        srw_cnt_r <= srw_cnt_r - 8'h01;
      end
      if (rst_go || susp_go) begin
        op_busy_r <= 1'b0;
      end else if (op_go || resume_go) begin
        op_busy_r <= 1'b1;
      end else if (i_engine_done) begin
        op_busy_r <= 1'b0;
      end
      if (op_go) begin
        o_op_addr <= addr_r;
        o_op_kind <= is_chip ? fsap_pkg::OP_CHIP :
                     (cmd_r == `FSAP_CMD_PP) ? fsap_pkg::OP_PROG :
                     (cmd_r == `FSAP_CMD_SE) ? fsap_pkg::OP_SECT :
                     (cmd_r == `FSAP_CMD_BE32) ? fsap_pkg::OP_BLK32 : fsap_pkg::OP_BLK64;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      erase_susp_r <= 1'b0;
      prog_susp_r <= 1'b0;
    end else if (susp_go) begin
      erase_susp_r <= (o_op_kind != fsap_pkg::OP_PROG);
      prog_susp_r <= (o_op_kind == fsap_pkg::OP_PROG);
    end else if (resume_go || rst_go) begin
      erase_susp_r <= 1'b0;
      prog_susp_r <= 1'b0;
    end
  end

  assign o_quad_io_enable = qe_r;
  assign o_drive_strength = drv_r;
  assign o_hold_reset_sel = hold_sel_r;
  assign o_dummy_cycle_select = dc_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_op_accepted;
    op_go ##1 o_op_start;
  endsequence
  sequence s_srw_started;
    srw_go ##1 busy [*8];
  endsequence

  chk_op_sets_busy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    op_go |-> s_op_accepted ##0 busy) else $error("busy not set by operation");
  chk_srw_busy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    srw_go |-> s_srw_started) else $error("busy dropped during status write");
  chk_lock_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ((lock_r & $past(lock_r)) == $past(lock_r))) else $error("lock bit cleared");
  chk_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_so_oe && cmd_r == `FSAP_CMD_RDSR3) |-> (live_val[4:1] == `FSAP_RSVD_ZERO))
    else $error("reserved bits not zero");
  chk_prot_refuse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (do_end && is_op && !is_chip && addr_prot) |=> !o_op_start)
    else $error("protected address accepted");
  chk_chip_erase: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (do_end && is_chip && !ce_ok) |=> !o_op_start) else $error("chip erase not refused");
  chk_resume_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (resume_go || rst_go) |=> (!erase_susp_r && !prog_susp_r ##1 !erase_susp_r))
    else $error("suspend flag survived resume");
  chk_all_prot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmp_r && bp_r[2:0] == `FSAP_BP_NONE) |-> addr_prot) else $error("array not protected");
  chk_none_prot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmp_r && bp_r[2:0] == `FSAP_BP_ALL) |-> !addr_prot) else $error("array protected");
  chk_lockdown: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (do_end && is_wrsr && mode_r[1]) |=> $stable(bp_r) && $stable(mode_r))
    else $error("status written in lock-down");
endmodule : fsap_status_regs

// ### inc/fsap_cfg.svh
// constants for the flash status register and array protection block
// Summary of operation
// - first status byte: mode-lo, protect, latch, busy
// - second byte: suspends, complement, locks, quad, mode-hi
// - lock bits set once, cleared only by reset
// - third byte: pin select, drive, reserved, dummy
// - two-bit drive strength stored and read back
// - pin select bit chooses hold or reset
// - protection mode split across bit 7 and 8
// - complement with code 000 protects everything
// - complement with code 111 protects nothing
// - complement, top bits 00: lower fraction protected
// - complement, top bits 01: upper fraction protected
// - complement, top bits 10: all but top KB
// - complement, top bits 11: all but bottom KB
// - no complement, top bits 11: bottom 4/8/16/32 KB
// - refuse program or erase inside protected range
// - chip erase only when nothing protected
// - busy flag high while program, erase, write
// - resume, soft reset, power cycle clear suspends
`ifndef FSAP_CFG_SVH
`define FSAP_CFG_SVH

`define FSAP_CMD_WREN 8'h06
`define FSAP_CMD_WRDI 8'h04
`define FSAP_CMD_RDSR1 8'h05
`define FSAP_CMD_RDSR2 8'h35
`define FSAP_CMD_RDSR3 8'h15
`define FSAP_CMD_WRSR1 8'h01
`define FSAP_CMD_WRSR2 8'h31
`define FSAP_CMD_WRSR3 8'h11
`define FSAP_CMD_PP 8'h02
`define FSAP_CMD_SE 8'h20
`define FSAP_CMD_BE32 8'h52
`define FSAP_CMD_BE64 8'hD8
`define FSAP_CMD_CE1 8'h60
`define FSAP_CMD_CE2 8'hC7
`define FSAP_CMD_SUSP 8'h75
`define FSAP_CMD_RESUME 8'h7A
`define FSAP_CMD_RSTEN 8'h66
`define FSAP_CMD_RST 8'h99

`define FSAP_BP_NONE 3'h0
`define FSAP_BP_ALL 3'h7
`define FSAP_BIG_UNIT 24'h040000
`define FSAP_SMALL_UNIT 24'h001000
`define FSAP_SMALL_MAX_STEP 3'h3
`define FSAP_MODE_SW 2'h0
`define FSAP_MODE_HW 2'h1

`define FSAP_RST_MODE 2'h0
`define FSAP_RST_BP 5'h00
`define FSAP_RST_LOCK 3'h0
`define FSAP_RST_DRV 2'h1
`define FSAP_RSVD_ZERO 4'h0
`define FSAP_BYTE_LAST 3'h7
`define FSAP_ADDR_LAST 2'h2

`define FSAP_CLK_PERIOD_NS 10
`define FSAP_SRW_TIME_NS 1000
`define FSAP_SRW_CYC ((`FSAP_SRW_TIME_NS + `FSAP_CLK_PERIOD_NS - 1) / `FSAP_CLK_PERIOD_NS)

`endif

// ### inc/fsap_pkg.sv
// types for the flash status register and array protection block
package fsap_pkg;
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_DONE} fsap_state_e;
  typedef enum logic [2:0] {OP_PROG, OP_SECT, OP_BLK32, OP_BLK64, OP_CHIP} fsap_op_e;
endpackage : fsap_pkg

// ### rtl/fsap_prot_decode.sv
// protected-range decoder for the block-protect and complement bits
`include "fsap_cfg.svh"
module fsap_prot_decode (
  input wire logic [4:0] i_bp,
  input wire logic i_cmp,
  input wire logic [23:0] i_addr,
  output logic o_protected,
  output logic o_chip_erase_ok
);
  logic [2:0] code;
  logic [2:0] step;
  logic [23:0] size;
  logic hit;

  // no clock: the verdict is ready before any operation starts
  always_comb begin
    code = i_bp[2:0];
    step = 3'h0;
    size = 24'h000000;
    hit = 1'b0;
    if (code == `FSAP_BP_NONE) begin
      hit = 1'b0;
    end else if (code == `FSAP_BP_ALL) begin
      hit = 1'b1;
    end else if (!i_bp[4]) begin
      step = code - 3'h1;
      size = `FSAP_BIG_UNIT << step;
      hit = i_bp[3] ? (i_addr < size) : (i_addr >= (24'h000000 - size));
    end else begin
      // codes 10X and 110 all mean 32 KB
      step = code[2] ? `FSAP_SMALL_MAX_STEP : (code - 3'h1);
      size = `FSAP_SMALL_UNIT << step;
      hit = i_bp[3] ? (i_addr < size) : (i_addr >= (24'h000000 - size));
    end
    // complement mode protects exactly what plain mode leaves open
    o_protected = hit ^ i_cmp;
    o_chip_erase_ok = ((code == `FSAP_BP_NONE) && !i_cmp) ||
                      ((code == `FSAP_BP_ALL) && i_cmp);
  end
endmodule : fsap_prot_decode

// ### testbench/fsap_spi_host.sv
// host-side spi master model driving the status register block in mode 0
module fsap_spi_host (
  input wire logic i_so,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock only runs inside a frame, 80 ns period
  task automatic start();
    o_cs_n = 1'b0;
    #40;
  endtask : start

  // read bit taken late in the high phase: device shifts it out after its synced fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_si = tx[i];
      #40;
      o_sclk = 1'b1;
      #38;
      rx[i] = i_so;
      #2;
      o_sclk = 1'b0;
    end
  endtask : xfer

  // data line flipped on release so a stale level is never mistaken for data
  task automatic stop();
    #40;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #160;
  endtask : stop
endmodule : fsap_spi_host

// ### testbench/flash_status_and_array_protect_tb_top.sv
// self-checking bench for the status registers and array protection
`include "fsap_cfg.svh"
module flash_status_and_array_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic eng_done = 1'b0;
  logic sclk, cs_n, si, so, so_oe, op_start, sus_req, res_req, soft_rst, qe, hrs, dcs;
  logic [1:0] drv;
  logic [23:0] op_addr;
  logic [7:0] v;
  fsap_pkg::fsap_op_e op_kind;
  fsap_pkg::fsap_op_e kinds [3] = '{fsap_pkg::OP_PROG, fsap_pkg::OP_SECT, fsap_pkg::OP_CHIP};
  logic [23:0] corner [8] = '{24'h000000, 24'h007FFF, 24'h008000, 24'h03FFFF,
    24'h040000, 24'h800000, 24'hFF7FFF, 24'hFFF000};
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int op_cnt = 0;
  int sus_cnt = 0;
  int res_cnt = 0;
  int rst_cnt = 0;
  int seed = 34393;

  always #5 clk = ~clk;

  fsap_status_regs u_fsap_status_regs (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
    .i_wp_n(wp_n), .i_engine_done(eng_done), .o_so(so), .o_so_oe(so_oe),
    .o_op_start(op_start), .o_op_kind(op_kind), .o_op_addr(op_addr),
    .o_suspend_req(sus_req), .o_resume_req(res_req), .o_soft_reset(soft_rst),
    .o_quad_io_enable(qe), .o_drive_strength(drv), .o_hold_reset_sel(hrs),
    .o_dummy_cycle_select(dcs)
  );

  fsap_spi_host u_fsap_spi_host (.i_so(so), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (op_start === 1'b1) op_cnt <= op_cnt + 1;
    if (sus_req === 1'b1) sus_cnt <= sus_cnt + 1;
    if (res_req === 1'b1) res_cnt <= res_cnt + 1;
    if (soft_rst === 1'b1) rst_cnt <= rst_cnt + 1;
    if (cyc == 80000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmd1(input logic [7:0] c);
    logic [7:0] r;
    u_fsap_spi_host.start();
    u_fsap_spi_host.xfer(c, r);
    u_fsap_spi_host.stop();
  endtask : cmd1

  task automatic cmd2(input logic [15:0] c, output logic [7:0] r);
    u_fsap_spi_host.start();
    u_fsap_spi_host.xfer(c[15:8], r);
    u_fsap_spi_host.xfer(c[7:0], r);
    u_fsap_spi_host.stop();
  endtask : cmd2

  task automatic cmd4(input logic [31:0] c);
    logic [7:0] r;
    u_fsap_spi_host.start();
    for (int k = 3; k >= 0; k--) u_fsap_spi_host.xfer(c[8*k+:8], r);
    u_fsap_spi_host.stop();
  endtask : cmd4

  task automatic expect_sr(input string nm, input logic [7:0] c, input logic [7:0] e);
    logic [7:0] r;
    cmd2({c, 8'h00}, r);
    check(nm, r, e);
  endtask : expect_sr

  // bounded poll of the busy bit
  task automatic wait_idle();
    logic [7:0] r;
    for (int k = 0; k < 40; k++) begin
      cmd2({`FSAP_CMD_RDSR1, 8'h00}, r);
      if (r[0] === 1'b0) return;
    end
    check("idle", r[0], 1'b0);
  endtask : wait_idle

  task automatic wrsr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    cmd1(`FSAP_CMD_WREN);
    cmd2({c, d}, r);
    wait_idle();
  endtask : wrsr

  task automatic pulse_done();
    @(posedge clk);
    #1 eng_done = 1'b1;
    @(posedge clk);
    #1 eng_done = 1'b0;
    wait_idle();
  endtask : pulse_done

  // protected test of one address; bp3 picks the low end, bp4 the 4 KB steps
  function automatic logic prot_exp(input logic [4:0] bp, input logic cmp, input logic [23:0] a);
    logic [24:0] sz;
    logic hit;
    if (bp[2:0] == 3'h0) return cmp;
    if (bp[2:0] == 3'h7) return ~cmp;
    if (bp[4]) sz = 25'h0001000 << (bp[2] ? 3'h3 : bp[2:0] - 3'h1);
    else sz = 25'h0040000 << (bp[2:0] - 3'h1);
    hit = bp[3] ? ({1'b0, a} < sz) : ({1'b0, a} >= 25'h1000000 - sz);
    return hit ^ cmp;
  endfunction : prot_exp

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [4:0] bp;
    logic cmp, exp_ok;
    logic [23:0] a;
    int j, n0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("so_oe", so_oe, 1'b0);
    expect_sr("sr1", `FSAP_CMD_RDSR1, 8'h00);
    expect_sr("sr2", `FSAP_CMD_RDSR2, 8'h00);
    expect_sr("sr3", `FSAP_CMD_RDSR3, 8'h20);
    check("drv", drv, 2'h1);
    for (int k = 0; k < 4; k++) begin
      a = 24'($random(seed));
      cmd1(`FSAP_CMD_WREN);
      cmd2({`FSAP_CMD_WRSR3, a[7:0]}, v);
      expect_sr("busy", `FSAP_CMD_RDSR1, 8'h01);
      wait_idle();
      expect_sr("sr3", `FSAP_CMD_RDSR3, a[7:0] & 8'hE1);
      check("drv", drv, a[6:5]);
      check("pin_sel", hrs, a[7]);
      check("dummy", dcs, a[0]);
    end
    cmd2({`FSAP_CMD_WRSR2, 8'h42}, v);
    expect_sr("no_wel", `FSAP_CMD_RDSR2, 8'h00);
    wrsr(`FSAP_CMD_WRSR2, 8'hBE);
    expect_sr("sr2", `FSAP_CMD_RDSR2, 8'h3A);
    check("quad", qe, 1'b1);
    wrsr(`FSAP_CMD_WRSR2, 8'h00);
    expect_sr("locks", `FSAP_CMD_RDSR2, 8'h38);
    wrsr(`FSAP_CMD_WRSR1, 8'h80);
    @(posedge clk);
    #1 wp_n = 1'b0;
    wrsr(`FSAP_CMD_WRSR1, 8'h00);
    expect_sr("hw_lock", `FSAP_CMD_RDSR1, 8'h80);
    @(posedge clk);
    #1 wp_n = 1'b1;
    wrsr(`FSAP_CMD_WRSR1, 8'h00);
    expect_sr("sr1", `FSAP_CMD_RDSR1, 8'h00);
    // suspend, resume and soft reset around running erase and program
    cmd1(`FSAP_CMD_WREN);
    cmd4({`FSAP_CMD_BE32, 24'h123456});
    check("kind", op_kind, fsap_pkg::OP_BLK32);
    check("addr", op_addr, 24'h123456);
    expect_sr("op_busy", `FSAP_CMD_RDSR1, 8'h01);
    cmd1(`FSAP_CMD_SUSP);
    expect_sr("esus", `FSAP_CMD_RDSR2, 8'hB8);
    expect_sr("sus_idle", `FSAP_CMD_RDSR1, 8'h00);
    cmd1(`FSAP_CMD_RESUME);
    expect_sr("resume", `FSAP_CMD_RDSR2, 8'h38);
    check("pulses", {sus_cnt[3:0], res_cnt[3:0]}, 8'h11);
    pulse_done();
    cmd1(`FSAP_CMD_WREN);
    cmd4({`FSAP_CMD_PP, 24'h000100});
    cmd1(`FSAP_CMD_SUSP);
    expect_sr("psus", `FSAP_CMD_RDSR2, 8'h3C);
    cmd1(`FSAP_CMD_RSTEN);
    cmd1(`FSAP_CMD_RST);
    expect_sr("rst_sus", `FSAP_CMD_RDSR2, 8'h38);
    expect_sr("rst_sr1", `FSAP_CMD_RDSR1, 8'h00);
    check("soft_rst", rst_cnt, 24'h1);
    cmd1(`FSAP_CMD_WREN);
    cmd4({`FSAP_CMD_BE64, 24'h7F0000});
    check("kind", op_kind, fsap_pkg::OP_BLK64);
    pulse_done();
    // random protect settings against boundary and random targets
    for (int n = 0; n < 24; n++) begin
      bp = 5'($random(seed));
      cmp = 1'($random(seed));
      j = $unsigned($random(seed)) % 3;
      a = 24'($random(seed));
      if (n % 2 == 0) a = corner[(n / 2) % 8];
      if (n % 8 == 1) bp[2:0] = 3'h0;
      if (n % 8 == 3) bp[2:0] = 3'h7;
      if (j == 1) a[11:0] = 12'h000;
      wrsr(`FSAP_CMD_WRSR1, {1'b0, bp, 2'b00});
      wrsr(`FSAP_CMD_WRSR2, {1'b0, cmp, 6'h00});
      n0 = op_cnt;
      cmd1(`FSAP_CMD_WREN);
      if (j == 2) begin
        exp_ok = (bp[2:0] == 3'h0 || bp[2:0] == 3'h7) && !prot_exp(bp, cmp, 24'h000000);
        cmd1(`FSAP_CMD_CE1);
        check("chip_ok", op_cnt - n0, exp_ok);
      end else begin
        exp_ok = !prot_exp(bp, cmp, a);
        cmd4({(j == 1) ? `FSAP_CMD_SE : `FSAP_CMD_PP, a});
        check("accept", op_cnt - n0, exp_ok);
      end
      if (exp_ok) begin
        check("kind", op_kind, kinds[j]);
        pulse_done();
      end
    end
    // power lock-down mode refuses writes until the next reset
    wrsr(`FSAP_CMD_WRSR3, 8'h00);
    wrsr(`FSAP_CMD_WRSR2, 8'h01);
    wrsr(`FSAP_CMD_WRSR3, 8'hE1);
    expect_sr("pwr_lock", `FSAP_CMD_RDSR3, 8'h00);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    wrsr(`FSAP_CMD_WRSR3, 8'h81);
    expect_sr("unlocked", `FSAP_CMD_RDSR3, 8'h81);
    close_out();
  end
endmodule : flash_status_and_array_protect_tb_top
